// file: design/xts_pkg.sv
// Package of opcode patterns, field positions and reset values for the instruction slice
`default_nettype none
package xts_pkg;
    localparam int InstrWidth = 12;
    localparam int DataWidth = 8;
    localparam int FileAddrWidth = 5;
    localparam int FileDepth = 32;
    localparam int PortSelWidth = 3;
    // Opcode patterns and masks
    localparam logic [11:0] DirMask = 12'h0ff8;
    localparam logic [11:0] DirOpcode = 12'h0000;
    localparam logic [11:0] XorLitMask = 12'h0f00;
    localparam logic [11:0] XorLitOpcode = 12'h0f00;
    localparam logic [11:0] FileOpMask = 12'h0fc0;
    localparam logic [11:0] XorFileOpcode = 12'h0180;
    localparam logic [11:0] SubFileOpcode = 12'h0080;
    // Field positions
    localparam int DestBit = 5;
    localparam int FileAddrLsb = 0;
    localparam int LiteralLsb = 0;
    // Valid port selectors
    localparam logic [2:0] PortASel = 3'h5;
    localparam logic [2:0] PortBSel = 3'h6;
    localparam logic [2:0] PortCSel = 3'h7;
    // Reset values
    localparam logic [7:0] AccReset = 8'h00;
    localparam logic [7:0] DirReset = 8'hff;
    localparam logic [7:0] DataZero = 8'h00;
    localparam logic FlagReset = 1'b0;
    typedef enum {XTS_OP_NONE, XTS_OP_DIR, XTS_OP_XORLIT, XTS_OP_XORFILE, XTS_OP_SUB} xts_op_t;
endpackage
`default_nettype wire

// file: design/xts_alu_if.sv
// Interface carrying operands and results between decoder and ALU
`timescale 1ns/100ps
`default_nettype none
interface xts_alu_if;
    import xts_pkg::*;
    xts_op_t op;
    logic [7:0] acc;
    logic [7:0] fileVal;
    logic [7:0] literal;
    logic [7:0] result;
    logic zero;
    logic carry;
    modport core (output op, output acc, output fileVal, output literal, input result, input zero, input carry);
    modport alu (input op, input acc, input fileVal, input literal, output result, output zero, output carry);
endinterface
`default_nettype wire

// file: design/xts_alu.sv
// Combinational ALU for exclusive-OR and subtract operations
`timescale 1ns/100ps
`default_nettype none
module xts_alu (
    xts_alu_if.alu bus
);
    import xts_pkg::*;
    // ==========================================
    // Result selection
    wire [8:0] subWide = {1'b0, bus.fileVal} - {1'b0, bus.acc};
    wire [7:0] xorLit = bus.acc ^ bus.literal;
    wire [7:0] xorFile = bus.acc ^ bus.fileVal;
    assign bus.result = (bus.op == XTS_OP_XORLIT) ? xorLit :
                        (bus.op == XTS_OP_XORFILE) ? xorFile : subWide[7:0];
    assign bus.zero = (bus.result == DataZero);
    // Carry is the inverted borrow: zero result sets it, negative clears it
    assign bus.carry = ~subWide[8];
endmodule
`default_nettype wire

// file: design/xts_core.sv
// Instruction slice core: direction load, exclusive-OR forms and subtract carry
`timescale 1ns/100ps
`default_nettype none
module xts_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instrValid,
    input wire logic [11:0] instr,
    output logic [7:0] accOut,
    output logic zeroFlag,
    output logic carryFlag,
    output logic [7:0] portADirection,
    output logic [7:0] portBDirection,
    output logic [7:0] portCDirection,
    output logic fileWrite,
    output logic [4:0] fileWriteAddr,
    output logic [7:0] fileWriteData
);
    import xts_pkg::*;
    // Masked opcode compare shared by every decode line
    function automatic logic opMatch(logic [11:0] word, logic [11:0] mask, logic [11:0] pattern);
        return (word & mask) == pattern;
    endfunction
    // ==========================================
    // State
    logic [7:0] acc_reg;
    logic zero_reg;
    logic carry_reg;
    logic [7:0] dirA_reg;
    logic [7:0] dirB_reg;
    logic [7:0] dirC_reg;
    logic [7:0] fileMem [FileDepth];
    logic fileWr_reg;
    logic [4:0] fileAddr_reg;
    logic [7:0] fileData_reg;
    xts_alu_if aluBus();
    // ==========================================
    // Decode
    wire isDir = instrValid && opMatch(instr, DirMask, DirOpcode);
    wire isXorLit = instrValid && opMatch(instr, XorLitMask, XorLitOpcode);
    wire isXorFile = instrValid && opMatch(instr, FileOpMask, XorFileOpcode);
    wire isSub = instrValid && opMatch(instr, FileOpMask, SubFileOpcode);
    wire [2:0] portSel = instr[PortSelWidth-1:0];
    wire [4:0] fileAddr = instr[FileAddrLsb +: FileAddrWidth];
    wire destFile = instr[DestBit];
    wire [7:0] literal = instr[LiteralLsb +: DataWidth];
    wire writeFile = (isXorFile || isSub) && destFile;
    wire writeAcc = isXorLit || ((isXorFile || isSub) && !destFile);
    assign aluBus.op = isXorLit ? XTS_OP_XORLIT : isXorFile ? XTS_OP_XORFILE :
                       isSub ? XTS_OP_SUB : isDir ? XTS_OP_DIR : XTS_OP_NONE;
    assign aluBus.acc = acc_reg;
    assign aluBus.fileVal = fileMem[fileAddr];
    assign aluBus.literal = literal;
    xts_alu alu (.bus(aluBus));
    // ==========================================
    // Accumulator and flags; direction load leaves flags alone
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            acc_reg <= AccReset;
            zero_reg <= FlagReset;
            carry_reg <= FlagReset;
        end else begin
            if (writeAcc) acc_reg <= aluBus.result;
            if (isXorLit || isXorFile) zero_reg <= aluBus.zero;
            if (isSub) carry_reg <= aluBus.carry;
        end
    end
    // ==========================================
    // Direction latches; selectors other than 5, 6, 7 are ignored
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dirA_reg <= DirReset;
            dirB_reg <= DirReset;
            dirC_reg <= DirReset;
        end else if (isDir) begin
            if (portSel == PortASel) dirA_reg <= acc_reg;
            if (portSel == PortBSel) dirB_reg <= acc_reg;
            if (portSel == PortCSel) dirC_reg <= acc_reg;
        end
    end
    // ==========================================
    // File register array; cleared by reset so file operands never stay unknown
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < FileDepth; i++) begin
                fileMem[i] <= DataZero;
            end
        end else if (writeFile) begin
            fileMem[fileAddr] <= aluBus.result;
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fileWr_reg <= 1'b0;
            fileAddr_reg <= 5'h00;
            fileData_reg <= DataZero;
        end else begin
            fileWr_reg <= writeFile;
            fileAddr_reg <= fileAddr;
            fileData_reg <= aluBus.result;
        end
    end
    assign accOut = acc_reg;
    assign zeroFlag = zero_reg;
    assign carryFlag = carry_reg;
    assign portADirection = dirA_reg;
    assign portBDirection = dirB_reg;
    assign portCDirection = dirC_reg;
    assign fileWrite = fileWr_reg;
    assign fileWriteAddr = fileAddr_reg;
    assign fileWriteData = fileData_reg;
endmodule
`default_nettype wire

// file: sim/xts_core_assertions.sv
// Checker for the instruction slice core
`timescale 1ns/100ps
`default_nettype none
module xts_core_assertions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instrValid,
    input wire logic [11:0] instr,
    input wire logic [7:0] accOut,
    input wire logic zeroFlag,
    input wire logic carryFlag,
    input wire logic [7:0] portADirection,
    input wire logic [7:0] portBDirection,
    input wire logic [7:0] portCDirection
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Decodes of the instruction word
    wire dirOp = instrValid && instr[11:3] == 9'h000;
    wire xorLit = instrValid && instr[11:8] == 4'hf;
    wire xorFile = instrValid && instr[11:6] == 6'h06;
    wire subAcc = instrValid && instr[11:5] == 7'h04;
    // ==========
    // Properties
    a_dir_copy: assert property (dirOp && instr[2:0] == 3'h6 |=> portBDirection == $past(accOut))
        else $error("direction latch missed accumulator");
    a_dir_refuse: assert property (dirOp && instr[2:0] < 3'h5 |=> $stable({portADirection, portBDirection, portCDirection}))
        else $error("bad selector changed a latch");
    a_dir_flags: assert property (dirOp |=> $stable({zeroFlag, carryFlag, accOut}))
        else $error("direction load changed state");
    a_xorlit_acc: assert property (xorLit |=> accOut == ($past(accOut) ^ $past(instr[7:0])) && $stable(carryFlag))
        else $error("literal xor result wrong");
    a_xor_zero: assert property (xorLit |=> zeroFlag == (accOut == 8'h00))
        else $error("zero flag wrong after xor");
    a_xorfile_dest: assert property (xorFile && instr[5] |=> $stable({accOut, carryFlag}))
        else $error("file xor touched accumulator");
    a_sub_carry: assert property (subAcc ##1 accOut == 8'h00 |-> carryFlag)
        else $error("zero difference without carry");
    a_sub_borrow: assert property (subAcc |=> carryFlag == ({1'b0, accOut} + {1'b0, $past(accOut)} <= 9'hff))
        else $error("carry disagrees with borrow");
endmodule
bind xts_core xts_core_assertions chk (.clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instr(instr),
    .accOut(accOut), .zeroFlag(zeroFlag), .carryFlag(carryFlag), .portADirection(portADirection),
    .portBDirection(portBDirection), .portCDirection(portCDirection));
`default_nettype wire

// file: sim/xts_core_tb_top.sv
// Self-checking testbench for the instruction slice core
`timescale 1ns/100ps
`default_nettype none
module xts_core_tb_top;
    import xts_pkg::*;
    logic clk = 0, reset_n = 0, instrValid = 0, zeroFlag, carryFlag, fileWrite;
    logic [11:0] instr = 12'h000;
    logic [7:0] accOut, portADirection, portBDirection, portCDirection, fileWriteData, acc;
    logic [4:0] fileWriteAddr;
    int badCount = 0, nCompared = 0;
    logic [20:0] rows [4] = '{{12'hf5a, 8'h5a, 1'b0}, {12'hf5a, 8'h00, 1'b1}, {12'hfb5, 8'hb5, 1'b0},
        {12'hfaf, 8'h1a, 1'b0}};
    xts_core uut (.clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instr(instr), .accOut(accOut),
        .zeroFlag(zeroFlag), .carryFlag(carryFlag), .portADirection(portADirection),
        .portBDirection(portBDirection), .portCDirection(portCDirection), .fileWrite(fileWrite),
        .fileWriteAddr(fileWriteAddr), .fileWriteData(fileWriteData));
    initial forever #2 clk = ~clk;
    // Compare and count
    task chk(string nm, logic [7:0] got, logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One instruction, valid for a single edge
    task run(logic [11:0] i);
        @(negedge clk) instr = i;
        instrValid = 1;
        @(negedge clk) instrValid = 0;
    endtask
    task endSim();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        #4000;
        badCount++;
        endSim();
    end
    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1;
        foreach (rows[k]) begin
            run(rows[k][20:9]);
            chk("acc", accOut, rows[k][8:1]);
            chk("zero", {7'h00, zeroFlag}, {7'h00, rows[k][0]});
        end
        $display("table done");
        @(negedge clk) reset_n = 0;
        @(negedge clk) reset_n = 1;
        chk("acc", accOut, AccReset);
        chk("flags", {6'h00, zeroFlag, carryFlag}, 8'h00);
        chk("dirB", portBDirection, DirReset);
        $display("reset done");
        acc = 8'h00;
        for (int s = 5; s < 8; s++) begin
            run(12'hf00 | 12'(s * 17));
            acc ^= 8'(s * 17);
            run(12'(s));
            chk("dir", s == 5 ? portADirection : s == 6 ? portBDirection : portCDirection, acc);
            chk("accKeep", accOut, acc);
            chk("flagKeep", {6'h00, zeroFlag, carryFlag}, 8'h00);
        end
        run(12'h004);
        chk("dirA", portADirection, 8'h55);
        // Back to back: latch takes accumulator from before the xor
        @(negedge clk) instr = 12'h006;
        instrValid = 1;
        @(negedge clk) instr = 12'hfff;
        @(negedge clk) instrValid = 0;
        chk("dirB", portBDirection, 8'h44);
        chk("acc", accOut, 8'hbb);
        run(12'h1a3);
        chk("acc", accOut, 8'hbb);
        chk("fileAddr", {fileWrite, 2'h0, fileWriteAddr}, 8'h83);
        chk("fileData", fileWriteData, 8'hbb);
        $display("awkward done");
        // Subtract carry and file forms; file register 1 starts cleared by the mid-run reset
        run(12'hfb9);
        run(12'h1a1);
        chk("fileData", fileWriteData, 8'h02);
        chk("fileAddr", {fileWrite, 2'h0, fileWriteAddr}, 8'h81);
        run(12'h081);
        chk("acc", accOut, 8'h00);
        chk("flags", {6'h00, zeroFlag, carryFlag}, 8'h01);
        run(12'hf03);
        run(12'h081);
        chk("acc", accOut, 8'hff);
        chk("flags", {6'h00, zeroFlag, carryFlag}, 8'h00);
        run(12'h0a1);
        chk("fileData", fileWriteData, 8'h03);
        chk("acc", accOut, 8'hff);
        run(12'hffc);
        run(12'h181);
        chk("acc", accOut, 8'h00);
        chk("flags", {6'h00, zeroFlag, carryFlag}, 8'h02);
        chk("fileAddr", {fileWrite, 2'h0, fileWriteAddr}, 8'h01);
        $display("subtract done");
        endSim();
    end
endmodule
`default_nettype wire
